// >>> logic/bcpf_pkg.sv
// Behaviour
// RL1 - phasing select high decodes 60 degree sensor codes, low decodes 120 degree codes
// RL2 - each valid code turns on one top and one bottom drive of different phases
// RL3 - invalid code without brake: all drives off, fault asserted
// RL4 - invalid code with brake: tops off, bottoms on, fault asserted
// RL5 - valid code, brake, enable high: tops off, bottoms on, no fault
// RL6 - valid code, brake, enable low: tops off, bottoms on, fault asserted
// RL7 - valid code, no brake, enable low: all drives off, fault asserted
// RL8 - overcurrent while running: all bottoms off, fault asserted
// RL9 - fault and top drive outputs are active low
// RL10 - each oscillator cycle start sets the modulation latch, and the current latch unless overcurrent is present
// RL11 - ramp at or above speed command resets modulation latch for the rest of the cycle
// RL12 - modulation gates only the bottom drives, the top stays on
// RL13 - overcurrent resets current latch at once, off until next cycle
// RL14 - at most one conduction pulse per oscillator cycle
// RL15 - fault on invalid code, enable low, overcurrent, undervoltage or overtemperature
// RL16 - any undervoltage flag: fault, tops off, bottoms held low
// RL17 - outside logic may feed fault back to enable for latched shutdown
// RL18 - brake overrides every other input for the drive outputs; the code puts undervoltage first, bottoms stay low
// RL19 - brake bottoms wait until every top drive is off
// RL20 - overtemperature acts exactly like enable low
// RL21 - forward 60 degree codes run 100, 110, 111, 011, 001, 000
// RL22 - ramp is a free-running counter, cycle start at wrap
package bcpf_pkg;
  localparam int         RAMP_W     = 8;
  localparam logic [7:0] RAMP_LAST  = 8'hff;
  localparam logic [7:0] SPEED_RST  = 8'h80;
  localparam int         ADDR_W     = 4;
  localparam logic [3:0] OFS_SPEED  = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam int         ST_INVALID = 0;
  localparam int         ST_DISABLE = 1;
  localparam int         ST_OVERCUR = 2;
  localparam int         ST_UNDERV  = 3;
  localparam int         ST_PWM     = 4;
  localparam int         ST_CURLIM  = 5;
  localparam int         ST_BRAKE   = 6;
  localparam int         ST_FAULT   = 7;
  localparam int         PIN_W      = 12;
  localparam logic [2:0] TOP_OFF_B  = 3'h7;
  localparam logic [2:0] LOW_OFF    = 3'h0;
  localparam logic [2:0] LOW_ALL    = 3'h7;
endpackage : bcpf_pkg

// >>> logic/bcpf_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bcpf_sync #(
  parameter int W = 12
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_b,
  // pins in, synchronised out
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);
  logic [W-1:0] stage1_q;
  logic [W-1:0] stage2_q;

  // two flops per pin, the first read only by the second
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
    end
  end

  assign pinOut = stage2_q;
endmodule : bcpf_sync
`default_nettype wire

// >>> logic/bcpf_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module bcpf_decoder (
  // sensor code and mode
  input  wire logic [2:0] sensorCode,
  input  wire logic       phase60,
  input  wire logic       forward,
  // decoded selection, active high, bit 0 is phase a
  output logic            codeValid,
  output logic      [2:0] topSel,
  output logic      [2:0] bottomSel
);
  function automatic logic [2:0] topPhase(input logic [2:0] step);
    unique case (step)
      3'h0, 3'h5: topPhase = 3'h1;
      3'h1, 3'h2: topPhase = 3'h2;
      default:    topPhase = 3'h4;
    endcase
  endfunction : topPhase

  function automatic logic [2:0] bottomPhase(input logic [2:0] step);
    unique case (step)
      3'h0, 3'h1: bottomPhase = 3'h4;
      3'h2, 3'h3: bottomPhase = 3'h1;
      default:    bottomPhase = 3'h2;
    endcase
  endfunction : bottomPhase

  logic [2:0] step;

  // code to commutation step
  always_comb begin
    step      = 3'h0;
    codeValid = 1'b1;
    if (phase60) begin // RL1
      unique case (sensorCode) // RL21
        3'b100:  step = 3'h0;
        3'b110:  step = 3'h1;
        3'b111:  step = 3'h2;
        3'b011:  step = 3'h3;
        3'b001:  step = 3'h4;
        3'b000:  step = 3'h5;
        default: codeValid = 1'b0;
      endcase
    end else begin
      unique case (sensorCode)
        3'b100:  step = 3'h0;
        3'b110:  step = 3'h1;
        3'b010:  step = 3'h2;
        3'b011:  step = 3'h3;
        3'b001:  step = 3'h4;
        3'b101:  step = 3'h5;
        default: codeValid = 1'b0;
      endcase
    end
  end

  // reverse swaps top and bottom phases
  always_comb begin
    topSel    = 3'h0;
    bottomSel = 3'h0;
    if (codeValid) begin // RL2
      topSel    = forward ? topPhase(step) : bottomPhase(step);
      bottomSel = forward ? bottomPhase(step) : topPhase(step);
    end
  end
endmodule : bcpf_decoder
`default_nettype wire

// >>> logic/bcpf_commutator.sv
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module bcpf_commutator (
  // clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_b,
  // rotor sensors and mode pins
  input  wire logic                       rotorSensorA,
  input  wire logic                       rotorSensorB,
  input  wire logic                       rotorSensorC,
  input  wire logic                       phaseSelect60,
  input  wire logic                       forwardSel,
  input  wire logic                       outputEnable,
  input  wire logic                       brake,
  // protection flags
  input  wire logic                       overCurrent,
  input  wire logic                       underVoltLogic,
  input  wire logic                       underVoltLowSideDriverSupply,
  input  wire logic                       underVoltReference,
  input  wire logic                       overTemp,
  // register port
  input  wire logic [bcpf_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [7:0]                 regWrData,
  input  wire logic                       regWrStrobe,
  input  wire logic                       regRdStrobe,
  output logic      [7:0]                 regRdData,
  // drive outputs
  output logic                            highSideDriveA_b,
  output logic                            highSideDriveB_b,
  output logic                            highSideDriveC_b,
  output logic                            lowSideDriveA,
  output logic                            lowSideDriveB,
  output logic                            lowSideDriveC,
  output logic                            fault_b
);
  logic [bcpf_pkg::PIN_W-1:0]  pinRaw;
  logic [bcpf_pkg::PIN_W-1:0]  pinSync;
  logic [2:0]                  sensorCode;
  logic                        phase60;
  logic                        fwd;
  logic                        enPin;
  logic                        brakeS;
  logic                        ocS;
  logic [2:0]                  uvS;
  logic                        otS;
  logic                        codeValid;
  logic [2:0]                  topSel;
  logic [2:0]                  bottomSel;
  logic                        enEff;
  logic                        uvAny;
  logic                        cycleStart;
  logic [bcpf_pkg::RAMP_W-1:0] rampCnt_q;
  logic [7:0]                  speed_q;
  logic                        pwmLatch_q;
  logic                        curLatch_q;
  logic [2:0]                  highSide_b_q;
  logic [2:0]                  highSide_b_d;
  logic [2:0]                  lowSide_q;
  logic [2:0]                  lowSide_d;
  logic                        fault_b_q;
  logic                        fault_b_d;
  logic [7:0]                  status;
  logic [7:0]                  rdData_q;
  logic                        gate;
  logic                        gatePrev_q;
  logic [1:0]                  pulseCnt_q;

  // pin synchronisers
  assign pinRaw = {rotorSensorA, rotorSensorB, rotorSensorC, phaseSelect60, forwardSel, outputEnable,
                   brake, overCurrent, underVoltLogic, underVoltLowSideDriverSupply, underVoltReference,
                   overTemp};

  bcpf_sync #(
    .W (bcpf_pkg::PIN_W)
  ) uSync (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .pinIn   (pinRaw),
    .pinOut  (pinSync)
  );

  assign sensorCode = pinSync[11:9];
  assign phase60    = pinSync[8];
  assign fwd        = pinSync[7];
  assign enPin      = pinSync[6];
  assign brakeS     = pinSync[5];
  assign ocS        = pinSync[4];
  assign uvS        = pinSync[3:1];
  assign otS        = pinSync[0];

  // commutation decode
  bcpf_decoder uDecoder (
    .sensorCode (sensorCode),
    .phase60    (phase60),
    .forward    (fwd),
    .codeValid  (codeValid),
    .topSel     (topSel),
    .bottomSel  (bottomSel)
  );

  assign enEff = enPin & ~otS; // RL20
  assign uvAny = |uvS;

  // ramp oscillator
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rampCnt_q <= '0;
    end else begin
      rampCnt_q <= rampCnt_q + 8'h01; // RL22
    end
  end

  assign cycleStart = (rampCnt_q == bcpf_pkg::RAMP_LAST); // RL22

  // modulation latch
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pwmLatch_q <= 1'b0;
    end else if (cycleStart) begin
      pwmLatch_q <= 1'b1; // RL10
    end else if (rampCnt_q >= speed_q) begin
      pwmLatch_q <= 1'b0; // RL11
    end
  end

  // current latch, a trip beats the cycle start
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      curLatch_q <= 1'b0;
    end else if (ocS) begin
      curLatch_q <= 1'b0; // RL13
    end else if (cycleStart) begin
      curLatch_q <= 1'b1; // RL10
    end
  end

  assign gate = pwmLatch_q & curLatch_q; // RL14

  // drive decision
  always_comb begin
    highSide_b_d = bcpf_pkg::TOP_OFF_B;
    lowSide_d    = bcpf_pkg::LOW_OFF;
    fault_b_d    = ~(~codeValid | ~enEff | ocS | uvAny); // RL15
    if (uvAny) begin
      lowSide_d = bcpf_pkg::LOW_OFF; // RL16
    end else if (brakeS) begin // RL18
      if (highSide_b_q == bcpf_pkg::TOP_OFF_B) begin
        lowSide_d = bcpf_pkg::LOW_ALL; // RL19 RL4 RL5 RL6
      end
    end else if (codeValid && enEff) begin
      highSide_b_d = ~topSel; // RL2 RL12
      if (gate && !ocS) begin
        lowSide_d = bottomSel; // RL8 RL11 RL13
      end
    end
  end

  // output flops, tops and fault low when active
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      highSide_b_q <= bcpf_pkg::TOP_OFF_B;
      lowSide_q    <= bcpf_pkg::LOW_OFF;
      fault_b_q    <= 1'b0;
    end else begin
      highSide_b_q <= highSide_b_d; // RL9
      lowSide_q    <= lowSide_d;
      fault_b_q    <= fault_b_d; // RL9
    end
  end

  assign highSideDriveA_b = highSide_b_q[0];
  assign highSideDriveB_b = highSide_b_q[1];
  assign highSideDriveC_b = highSide_b_q[2];
  assign lowSideDriveA    = lowSide_q[0];
  assign lowSideDriveB    = lowSide_q[1];
  assign lowSideDriveC    = lowSide_q[2];
  assign fault_b          = fault_b_q;

  // speed command register
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      speed_q <= bcpf_pkg::SPEED_RST;
    end else if (regWrStrobe && regAddr == bcpf_pkg::OFS_SPEED) begin
      speed_q <= regWrData;
    end
  end

  // status and read data
  always_comb begin
    status                       = 8'h00;
    status[bcpf_pkg::ST_INVALID] = ~codeValid;
    status[bcpf_pkg::ST_DISABLE] = ~enEff;
    status[bcpf_pkg::ST_OVERCUR] = ocS;
    status[bcpf_pkg::ST_UNDERV]  = uvAny;
    status[bcpf_pkg::ST_PWM]     = pwmLatch_q;
    status[bcpf_pkg::ST_CURLIM]  = curLatch_q;
    status[bcpf_pkg::ST_BRAKE]   = brakeS;
    status[bcpf_pkg::ST_FAULT]   = ~fault_b_q;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rdData_q <= 8'h00;
    end else if (regRdStrobe) begin
      unique case (regAddr)
        bcpf_pkg::OFS_SPEED:  rdData_q <= speed_q;
        bcpf_pkg::OFS_STATUS: rdData_q <= status;
        default:              rdData_q <= 8'h00;
      endcase
    end else begin
      rdData_q <= 8'h00;
    end
  end

  assign regRdData = rdData_q;

  // conduction pulses per cycle, checking aid
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      gatePrev_q <= 1'b0;
      pulseCnt_q <= 2'h0;
    end else begin
      gatePrev_q <= gate;
      if (cycleStart) begin
        pulseCnt_q <= 2'h0;
      end else if (gate && !gatePrev_q && pulseCnt_q != 2'h3) begin
        pulseCnt_q <= pulseCnt_q + 2'h1;
      end
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  chk_fault_causes: assert property ( // RL15
    (!codeValid || !enEff || ocS || uvAny) |=> !fault_b)
    else $error("fault not asserted on a cause");

  chk_invalid_off: assert property ( // RL3
    (!codeValid && !brakeS && !uvAny) |=> (highSide_b_q == 3'h7 && lowSide_q == 3'h0 && !fault_b))
    else $error("invalid code did not switch all off");

  chk_invalid_brake: assert property ( // RL4
    (!codeValid && brakeS && !uvAny) [*2] |=> (highSide_b_q == 3'h7 && lowSide_q == 3'h7 && !fault_b))
    else $error("invalid code with brake wrong");

  chk_brake_ok: assert property ( // RL5
    (codeValid && brakeS && enEff && !ocS && !uvAny) [*2] |=> (lowSide_q == 3'h7 && fault_b))
    else $error("brake with enable wrong");

  chk_brake_disabled: assert property ( // RL6
    (codeValid && brakeS && !enEff && !uvAny) [*2] |=> (lowSide_q == 3'h7 && !fault_b))
    else $error("brake without enable wrong");

  chk_disable_off: assert property ( // RL7
    (codeValid && !brakeS && !enEff && !uvAny) |=> (lowSide_q == 3'h0 && highSide_b_q == 3'h7))
    else $error("disabled drives not off");

  chk_overcur_bottom: assert property ( // RL8
    (ocS && !brakeS) |=> (lowSide_q == 3'h0 && !fault_b))
    else $error("overcurrent left a bottom on");

  chk_cycle_set: assert property ( // RL10
    (cycleStart && !ocS) |=> (pwmLatch_q && curLatch_q))
    else $error("cycle start did not set latches");

  chk_pwm_end: assert property ( // RL11
    (rampCnt_q > speed_q && $stable(speed_q)) |-> !pwmLatch_q ##1 (lowSide_q == 3'h0 || $past(brakeS)))
    else $error("modulation latch not reset");

  chk_top_steady: assert property ( // RL12
    (codeValid && enEff && !brakeS && !uvAny && !ocS && !gate && $stable(sensorCode))
      |=> (highSide_b_q == ~$past(topSel)))
    else $error("top drive gated by modulation");

  chk_trip_hold: assert property ( // RL13
    (ocS && !cycleStart) ##1 (!cycleStart) |-> !curLatch_q)
    else $error("current latch released before cycle start");

  chk_one_pulse: assert property ( // RL14
    pulseCnt_q <= 2'h1)
    else $error("more than one pulse in a cycle");

  chk_undervolt: assert property ( // RL16
    uvAny |=> (highSide_b_q == 3'h7 && lowSide_q == 3'h0 && !fault_b))
    else $error("undervoltage outputs wrong");

  chk_brake_interlock: assert property ( // RL19
    (lowSide_q == 3'h7) |-> (highSide_b_q == 3'h7 && $past(highSide_b_q) == 3'h7))
    else $error("bottoms on while a top conducts");

  chk_overtemp: assert property ( // RL20
    (otS && !brakeS) |=> (lowSide_q == 3'h0 && highSide_b_q == 3'h7 && !fault_b))
    else $error("overtemperature not acting as disable");
endmodule : bcpf_commutator
`default_nettype wire

// >>> verif/bcpf_bridge_model.sv
`timescale 1ns/1ps
`default_nettype none
module bcpf_bridge_model (
  // drive pins from the controller
  input  wire logic [2:0] topOn_b,
  input  wire logic [2:0] bottomOn,
  // load behaviour chosen by the bench
  input  wire logic       stallLoad,
  // sense and health
  output logic            senseOver,
  output logic            shootThrough
);
  // a stalled winding keeps the sense voltage above threshold
  assign senseOver    = stallLoad;
  // top and bottom of one phase together short the motor rail
  assign shootThrough = |(~topOn_b & bottomOn);
endmodule : bcpf_bridge_model
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic       sys_clk   = 1'b0;
  logic       rst_b     = 1'b0;
  logic [2:0] sensor    = 3'h4;
  logic       phase60   = 1'b1;
  logic       fwd       = 1'b1;
  logic       enable    = 1'b1;
  logic       brake     = 1'b0;
  logic       stall     = 1'b0;
  logic       hot       = 1'b0;
  logic [2:0] uv        = 3'h0;
  logic [3:0] regAddr   = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic       regWr     = 1'b0;
  logic       regRd     = 1'b0;
  logic [7:0] regRdData;
  logic [2:0] tops_b;
  logic [2:0] bots;
  logic       fault_b;
  logic       overCur;
  logic       shoot;
  logic [7:0] rdv;
  int         failures = 0;
  int         checks_done = 0;
  int         cycles = 0;
  int         shootSeen = 0;
  int         onCount;
  int         offCount;
  logic [2:0] c60 [6] = '{3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0};
  logic [2:0] c120 [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};
  logic [2:0] ph1 [6] = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h4, 3'h1};
  logic [2:0] ph2 [6] = '{3'h4, 3'h4, 3'h1, 3'h1, 3'h2, 3'h2};
  logic [2:0] bad [4] = '{3'h7, 3'h0, 3'h2, 3'h5};

  always #2.5 sys_clk = ~sys_clk;

  bcpf_commutator DUT (
    .sys_clk(sys_clk), .rst_b(rst_b),
    .rotorSensorA(sensor[2]), .rotorSensorB(sensor[1]), .rotorSensorC(sensor[0]),
    .phaseSelect60(phase60), .forwardSel(fwd), .outputEnable(enable), .brake(brake),
    .overCurrent(overCur), .underVoltLogic(uv[0]), .underVoltLowSideDriverSupply(uv[1]),
    .underVoltReference(uv[2]), .overTemp(hot),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWr), .regRdStrobe(regRd),
    .regRdData(regRdData),
    .highSideDriveA_b(tops_b[0]), .highSideDriveB_b(tops_b[1]), .highSideDriveC_b(tops_b[2]),
    .lowSideDriveA(bots[0]), .lowSideDriveB(bots[1]), .lowSideDriveC(bots[2]),
    .fault_b(fault_b)
  );

  bcpf_bridge_model bridge (
    .topOn_b(tops_b), .bottomOn(bots), .stallLoad(stall),
    .senseOver(overCur), .shootThrough(shoot)
  );

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (rst_b === 1'b1 && shoot !== 1'b0) shootSeen <= shootSeen + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      tally_and_finish();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge sys_clk);
    regWr     <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd   <= 1'b0;
    #1 d = regRdData;
  endtask : rd

  task automatic settle(input logic [2:0] code);
    @(posedge sys_clk);
    sensor <= code;
    repeat (8) @(posedge sys_clk);
    #1;
  endtask : settle

  // topOn is active high here; the pins are compared inverted
  task automatic expect_out(input logic [2:0] topOn, input logic [2:0] botOn, input logic flt_b);
    check({13'h0, tops_b}, {13'h0, ~topOn});
    check({13'h0, bots}, {13'h0, botOn});
    check({15'h0, fault_b}, {15'h0, flt_b});
  endtask : expect_out

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(bcpf_pkg::OFS_SPEED, rdv);
    check({8'h0, rdv}, {8'h0, bcpf_pkg::SPEED_RST});
    wr(bcpf_pkg::OFS_SPEED, 8'hff);
    wr(bcpf_pkg::OFS_STATUS, 8'h00);
    rd(4'hf, rdv);
    check({8'h0, rdv}, 16'h0000);
    rd(bcpf_pkg::OFS_SPEED, rdv);
    check({8'h0, rdv}, 16'h00ff);
    repeat (300) @(posedge sys_clk);
    $display("test registers done");
    for (int m = 0; m < 2; m++) begin
      for (int d = 0; d < 2; d++) begin
        phase60 <= m[0];
        fwd     <= d[0];
        for (int s = 0; s < 6; s++) begin
          settle(m ? c60[s] : c120[s]);
          if (d) expect_out(ph1[s], ph2[s], 1'b1);
          else expect_out(ph2[s], ph1[s], 1'b1);
        end
      end
    end
    $display("test commutation done");
    for (int k = 0; k < 4; k++) begin
      phase60 <= k[1];
      brake   <= 1'b0;
      settle(bad[k]);
      expect_out(3'h0, bcpf_pkg::LOW_OFF, 1'b0);
      brake <= 1'b1;
      settle(bad[k]);
      expect_out(3'h0, bcpf_pkg::LOW_ALL, 1'b0);
    end
    rd(bcpf_pkg::OFS_STATUS, rdv);
    check({8'h0, rdv & 8'hcf}, 16'h00c1);
    $display("test invalid codes done");
    settle(3'h4);
    expect_out(3'h0, bcpf_pkg::LOW_ALL, 1'b1);
    enable <= 1'b0;
    settle(3'h4);
    expect_out(3'h0, bcpf_pkg::LOW_ALL, 1'b0);
    brake <= 1'b0;
    settle(3'h4);
    expect_out(3'h0, bcpf_pkg::LOW_OFF, 1'b0);
    enable <= 1'b1;
    hot    <= 1'b1;
    settle(3'h4);
    expect_out(3'h0, bcpf_pkg::LOW_OFF, 1'b0);
    brake <= 1'b1;
    settle(3'h4);
    expect_out(3'h0, bcpf_pkg::LOW_ALL, 1'b0);
    hot <= 1'b0;
    for (int u = 0; u < 3; u++) begin
      uv <= 3'h1 << u;
      settle(3'h4);
      expect_out(3'h0, bcpf_pkg::LOW_OFF, 1'b0);
    end
    uv    <= 3'h0;
    brake <= 1'b0;
    $display("test brake enable supply done");
    stall <= 1'b1;
    settle(3'h4);
    check({13'h0, bots}, 16'h0000);
    check({15'h0, fault_b}, 16'h0000);
    enable <= fault_b;
    stall  <= 1'b0;
    settle(3'h4);
    expect_out(3'h0, bcpf_pkg::LOW_OFF, 1'b0);
    enable <= 1'b1;
    repeat (300) @(posedge sys_clk);
    #1 expect_out(3'h1, 3'h4, 1'b1);
    $display("test overcurrent done");
    wr(bcpf_pkg::OFS_SPEED, 8'h40);
    repeat (300) @(posedge sys_clk);
    onCount  = 0;
    offCount = 0;
    repeat (1024) begin
      @(posedge sys_clk);
      #1;
      if (bots[2] === 1'b1) onCount++;
      if (tops_b[0] !== 1'b0) offCount++;
    end
    check(onCount[15:0], 16'd260);
    check(offCount[15:0], 16'd0);
    check(shootSeen[15:0], 16'd0);
    $display("test modulation done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
